// *** design/ltc_pkg.sv ***
// shared constants and carrier types for the light threshold configuration block
package ltc_pkg;

    // register offsets
    localparam logic [7:0] LTC_OFS_THR_LO = 8'h08;
    localparam logic [7:0] LTC_OFS_THR_HI = 8'h09;
    localparam logic [7:0] LTC_OFS_CFG    = 8'h0A;

    // reset values
    localparam logic [15:0] LTC_RST_THR_LO = 16'h0000;
    localparam logic [15:0] LTC_RST_THR_HI = 16'hBFFF;
    localparam logic [15:0] LTC_RST_CFG    = 16'h3208;

    // field positions
    localparam int LTC_EXP_MSB   = 15;
    localparam int LTC_EXP_LSB   = 12;
    localparam int LTC_MANT_MSB  = 11;
    localparam int LTC_WO_BIT    = 14;

    // range and mode codes
    localparam logic [3:0] LTC_RANGE_MAX_FIXED = 4'h6;
    localparam logic [3:0] LTC_RANGE_AUTO      = 4'hC;
    localparam logic [1:0] LTC_MODE_OFF        = 2'h0;
    localparam logic [1:0] LTC_MODE_ONE_AUTO   = 2'h1;
    localparam logic [1:0] LTC_MODE_ONE        = 2'h2;
    localparam logic [1:0] LTC_MODE_CONT       = 2'h3;

    localparam int LTC_NUM_CH     = 4;
    localparam int LTC_NUM_CTIME  = 12;
    localparam int LTC_CNT_W      = 24;

    // conversion time per channel in microseconds, and cycles at the clock rate
    localparam int unsigned LTC_CLK_MHZ = 20;
    localparam int unsigned LTC_CONV_US [LTC_NUM_CTIME] = '{600, 1000, 1800, 3400, 6500, 12700,
                                                          25000, 50000, 100000, 200000, 400000, 800000};
    localparam int unsigned LTC_CONV_CYC [LTC_NUM_CTIME] = '{
        LTC_CONV_US[0] * LTC_CLK_MHZ, LTC_CONV_US[1] * LTC_CLK_MHZ, LTC_CONV_US[2] * LTC_CLK_MHZ,
        LTC_CONV_US[3] * LTC_CLK_MHZ, LTC_CONV_US[4] * LTC_CLK_MHZ, LTC_CONV_US[5] * LTC_CLK_MHZ,
        LTC_CONV_US[6] * LTC_CLK_MHZ, LTC_CONV_US[7] * LTC_CLK_MHZ, LTC_CONV_US[8] * LTC_CLK_MHZ,
        LTC_CONV_US[9] * LTC_CLK_MHZ, LTC_CONV_US[10] * LTC_CLK_MHZ, LTC_CONV_US[11] * LTC_CLK_MHZ};

    typedef struct packed {
        logic [3:0]  exp;
        logic [11:0] mant;
    } ltc_thr_t;

    typedef struct packed {
        logic       fast_wake;
        logic       wo_zero;
        logic [3:0] range;
        logic [3:0] conv_time;
        logic [1:0] mode;
        logic       latch;
        logic       alert_pin_level;
        logic [1:0] fault_count;
    } ltc_cfg_t;

    typedef enum logic [2:0] {
        LTC_ST_IDLE = 3'b001,
        LTC_ST_CONV = 3'b010,
        LTC_ST_NEXT = 3'b100
    } ltc_state_t;

endpackage

// *** design/ltc_seq.sv ***
// conversion sequencer: walks the four channels at the configured conversion time
`timescale 1ns/1ns
module ltc_seq #(
    parameter int unsigned CONV_CYC [ltc_pkg::LTC_NUM_CTIME] = ltc_pkg::LTC_CONV_CYC
) (
    input  wire logic                   clk_i,
    input  wire logic                   arst_n_i,
    input  wire logic [1:0]             mode_i,
    input  wire logic [3:0]             conv_time_i,
    input  wire logic                   oneshot_go_i,
    output logic                        conv_start_o,
    output logic                        chan_done_o,
    output logic                        oneshot_done_o,
    output logic [1:0]                  chan_o,
    output logic                        busy_o
);
    ltc_pkg::ltc_state_t             state_ff;
    ltc_pkg::ltc_state_t             nxt_state;
    logic [ltc_pkg::LTC_CNT_W-1:0]   cnt_ff;
    logic                            oneshot_ff;
    logic                            cont;
    logic                            expired;
    logic                            last_ch;
    logic [ltc_pkg::LTC_CNT_W-1:0]   limit;

    assign cont    = (mode_i == ltc_pkg::LTC_MODE_CONT);
    // codes above the table fall back to the longest time
    assign limit   = (conv_time_i < 4'(ltc_pkg::LTC_NUM_CTIME))
                   ? ltc_pkg::LTC_CNT_W'(CONV_CYC[conv_time_i] - 1)
                   : ltc_pkg::LTC_CNT_W'(CONV_CYC[ltc_pkg::LTC_NUM_CTIME-1] - 1);
    assign expired = (cnt_ff >= limit);
    assign last_ch = (chan_o == 2'(ltc_pkg::LTC_NUM_CH - 1));

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ltc_pkg::LTC_ST_IDLE: begin
                if (cont || oneshot_go_i) begin
                    nxt_state = ltc_pkg::LTC_ST_CONV;
                end
            end
            ltc_pkg::LTC_ST_CONV: begin
                if (expired) begin
                    nxt_state = ltc_pkg::LTC_ST_NEXT;
                end
            end
            ltc_pkg::LTC_ST_NEXT: begin
                // continuous restarts at once; one-shot stops after channel 3
                if (!last_ch || (cont && !oneshot_ff)) begin
                    nxt_state = ltc_pkg::LTC_ST_CONV;
                end else begin
                    nxt_state = ltc_pkg::LTC_ST_IDLE;
                end
            end
            default: nxt_state = ltc_pkg::LTC_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_ff       <= ltc_pkg::LTC_ST_IDLE;
            cnt_ff         <= '0;
            oneshot_ff     <= 1'b0;
            chan_o         <= 2'h0;
            conv_start_o   <= 1'b0;
            chan_done_o    <= 1'b0;
            oneshot_done_o <= 1'b0;
            busy_o         <= 1'b0;
        end else begin
            state_ff       <= nxt_state;
            cnt_ff         <= (state_ff == ltc_pkg::LTC_ST_CONV && !expired) ? cnt_ff + 1'b1 : '0;
            conv_start_o   <= (nxt_state == ltc_pkg::LTC_ST_CONV) && (state_ff != ltc_pkg::LTC_ST_CONV);
            chan_done_o    <= (state_ff == ltc_pkg::LTC_ST_CONV) && expired;
            oneshot_done_o <= (state_ff == ltc_pkg::LTC_ST_NEXT) && (nxt_state == ltc_pkg::LTC_ST_IDLE)
                              && oneshot_ff;
            busy_o         <= (nxt_state != ltc_pkg::LTC_ST_IDLE);
            if (state_ff == ltc_pkg::LTC_ST_IDLE && nxt_state == ltc_pkg::LTC_ST_CONV) begin
                oneshot_ff <= !cont;
                chan_o     <= 2'h0;
            end else if (state_ff == ltc_pkg::LTC_ST_NEXT) begin
                chan_o     <= chan_o + 2'h1;
            end
        end
    end
endmodule

// *** design/ltc_cmp.sv ***
// threshold comparison, fault-count filter, flags and alert pin
`timescale 1ns/1ns
module ltc_cmp (
    input  wire logic               clk_i,
    input  wire logic               arst_n_i,
    input  wire logic               sample_i,
    input  wire ltc_pkg::ltc_thr_t  value_i,
    input  wire ltc_pkg::ltc_thr_t  thr_lo_i,
    input  wire ltc_pkg::ltc_thr_t  thr_hi_i,
    input  wire logic [1:0]         fault_count_i,
    input  wire logic               latch_i,
    input  wire logic               alert_pin_level_i,
    input  wire logic               flag_clear_i,
    output logic                    flag_hi_o,
    output logic                    flag_lo_o,
    output logic                    alert_o
);
    logic [3:0] hi_cnt_ff;
    logic [3:0] lo_cnt_ff;
    logic [3:0] need;
    logic       over;
    logic       under;
    logic       hi_hit;
    logic       lo_hit;
    logic       nxt_hi;
    logic       nxt_lo;

    // mantissa scaled by its exponent; the 27-bit result holds every exponent up to 15 without saturating
    function automatic logic [26:0] lin(input ltc_pkg::ltc_thr_t v);
        lin = {15'h0000, v.mant} << v.exp;
    endfunction

    assign need   = 4'h1 << fault_count_i;
    assign over   = lin(value_i) > lin(thr_hi_i);
    assign under  = lin(value_i) < lin(thr_lo_i);
    assign hi_hit = sample_i && over && (hi_cnt_ff + 4'h1 >= need);
    assign lo_hit = sample_i && under && (lo_cnt_ff + 4'h1 >= need);

    // latched flags hold until cleared, a new hit beats a clear in the same cycle
    always_comb begin
        nxt_hi = flag_hi_o;
        nxt_lo = flag_lo_o;
        if (latch_i) begin
            if (flag_clear_i) begin
                nxt_hi = 1'b0;
                nxt_lo = 1'b0;
            end
        end else if (sample_i) begin
            nxt_hi = 1'b0;
            nxt_lo = 1'b0;
        end
        if (hi_hit) begin
            nxt_hi = 1'b1;
        end
        if (lo_hit) begin
            nxt_lo = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hi_cnt_ff <= 4'h0;
            lo_cnt_ff <= 4'h0;
            flag_hi_o <= 1'b0;
            flag_lo_o <= 1'b0;
            alert_o   <= 1'b1;
        end else begin
            if (sample_i) begin
                hi_cnt_ff <= over ? ((hi_cnt_ff < 4'h8) ? hi_cnt_ff + 4'h1 : hi_cnt_ff) : 4'h0;
                lo_cnt_ff <= under ? ((lo_cnt_ff < 4'h8) ? lo_cnt_ff + 4'h1 : lo_cnt_ff) : 4'h0;
            end
            flag_hi_o <= nxt_hi;
            flag_lo_o <= nxt_lo;
            alert_o   <= (nxt_hi || nxt_lo) ~^ alert_pin_level_i;
        end
    end
endmodule

// *** design/ltc_top.sv ***
// threshold and main configuration registers with the logic they steer
//
// Notes on behaviour
// - the low threshold word holds a 4-bit exponent in 15:12 and a 12-bit result in 11:0, read/write, reset 0.
// - the high threshold word has the same layout, read/write, and resets to BFFFh.
// - range bits 13:10 pick the full scale, codes 0..6 fixed scales, code 12 auto-ranging, reset 12.
// - for codes 0..6 the range code equals the exponent code reported with results, except in the forced auto-range one-shot mode.
// - bits 9:6 set the per-channel conversion time from 600 us up to 800 ms, reset code 8.
// - bits 5:4 pick power-down, forced auto-range one-shot, one-shot or continuous, reset power-down.
// - bit 15 keeps part of the front end powered in standby for a faster wake, whenever idle and not in continuous mode.
// - bit 3 picks latched or non-latched threshold reporting, reset 1.
// - bit 2 sets the alert pin active level, 0 low and 1 high, reset low.
// - bits 1:0 need 1, 2, 4 or 8 consecutive violations before a flag rises.
// - each result exponent names the full-scale range the measurement was taken in.
// - a 2-bit selector picks which channel the threshold logic watches.
`timescale 1ns/1ns
module ltc_top #(
    parameter int unsigned CONV_CYC [ltc_pkg::LTC_NUM_CTIME] = ltc_pkg::LTC_CONV_CYC
) (
    input  wire logic               clk_i,
    input  wire logic               arst_n_i,
    input  wire logic [7:0]         reg_addr_i,
    input  wire logic               reg_wr_i,
    input  wire logic [15:0]        reg_wdata_i,
    input  wire logic               reg_rd_i,
    output logic [15:0]             reg_rdata_o,
    output logic                    reg_hit_o,
    input  wire logic [1:0]         compare_channel_sel_i,
    input  wire logic               flag_clear_i,
    input  wire logic [3:0]         adc_exp_i,
    input  wire logic [11:0]        adc_mant_i,
    output logic                    conv_start_o,
    output logic [1:0]              conv_chan_o,
    output logic [3:0]              conv_range_o,
    output logic                    conv_auto_o,
    output logic [3:0]              conv_time_o,
    output logic                    fe_power_o,
    output logic                    fe_keep_alive_o,
    output logic                    result_valid_o,
    output logic [1:0]              result_chan_o,
    output logic [3:0]              result_exp_o,
    output logic [11:0]             result_mant_o,
    output logic                    flag_hi_o,
    output logic                    flag_lo_o,
    output logic                    alert_o,
    output logic                    busy_o
);
    ltc_pkg::ltc_thr_t  thr_lo_ff;
    ltc_pkg::ltc_thr_t  thr_hi_ff;
    ltc_pkg::ltc_cfg_t  cfg_ff;
    ltc_pkg::ltc_cfg_t  nxt_cfg;
    ltc_pkg::ltc_thr_t  sample_val;
    logic               auto_run_ff;

    logic               wr_lo;
    logic               wr_hi;
    logic               wr_cfg;
    logic               hit;
    logic [15:0]        rd_mux;
    logic               oneshot_go;
    logic               seq_start;
    logic               seq_done;
    logic               seq_end;
    logic [1:0]         seq_chan;
    logic               seq_busy;
    logic               range_fixed;
    logic               sample;
    logic               nxt_auto;

    // address decode for the three registers held here
    assign wr_lo  = reg_wr_i && (reg_addr_i == ltc_pkg::LTC_OFS_THR_LO);
    assign wr_hi  = reg_wr_i && (reg_addr_i == ltc_pkg::LTC_OFS_THR_HI);
    assign wr_cfg = reg_wr_i && (reg_addr_i == ltc_pkg::LTC_OFS_CFG);
    assign hit    = (reg_addr_i == ltc_pkg::LTC_OFS_THR_LO) || (reg_addr_i == ltc_pkg::LTC_OFS_THR_HI)
                 || (reg_addr_i == ltc_pkg::LTC_OFS_CFG);

    // bit 14 is write-only and always reads back zero
    assign rd_mux = (reg_addr_i == ltc_pkg::LTC_OFS_THR_LO) ? thr_lo_ff :
                    (reg_addr_i == ltc_pkg::LTC_OFS_THR_HI) ? thr_hi_ff :
                    (reg_addr_i == ltc_pkg::LTC_OFS_CFG)
                        ? (cfg_ff & ~(16'h0001 << ltc_pkg::LTC_WO_BIT)) : 16'h0000;

    // a write of either one-shot code kicks off a single sweep
    assign oneshot_go = wr_cfg && ((reg_wdata_i[5:4] == ltc_pkg::LTC_MODE_ONE_AUTO)
                                || (reg_wdata_i[5:4] == ltc_pkg::LTC_MODE_ONE));

    // the configuration word; the sequencer drops the mode back to power-down
    // after a one-shot, unless the host writes in that very cycle
    always_comb begin
        nxt_cfg = cfg_ff;
        if (seq_end && (cfg_ff.mode != ltc_pkg::LTC_MODE_CONT)) begin
            nxt_cfg.mode = ltc_pkg::LTC_MODE_OFF;
        end
        if (wr_cfg) begin
            nxt_cfg = reg_wdata_i;
            nxt_cfg.wo_zero = 1'b0;
        end
    end

    // range code 12 and the forced auto one-shot mode both let the front end pick the range
    assign range_fixed = (cfg_ff.range <= ltc_pkg::LTC_RANGE_MAX_FIXED);
    assign nxt_auto    = oneshot_go ? (reg_wdata_i[5:4] == ltc_pkg::LTC_MODE_ONE_AUTO)
                       : auto_run_ff && (cfg_ff.mode != ltc_pkg::LTC_MODE_CONT);

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            thr_lo_ff <= ltc_pkg::LTC_RST_THR_LO;
            thr_hi_ff <= ltc_pkg::LTC_RST_THR_HI;
            cfg_ff    <= ltc_pkg::LTC_RST_CFG;
        end else begin
            if (wr_lo) begin
                thr_lo_ff <= reg_wdata_i;
            end
            if (wr_hi) begin
                thr_hi_ff <= reg_wdata_i;
            end
            cfg_ff <= nxt_cfg;
        end
    end

    // read port answers one cycle after the strobe; unmapped offsets read zero
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= 16'h0000;
            reg_hit_o   <= 1'b0;
        end else begin
            reg_rdata_o <= reg_rd_i ? rd_mux : reg_rdata_o;
            reg_hit_o   <= (reg_rd_i || reg_wr_i) && hit;
        end
    end

    ltc_seq #(
        .CONV_CYC       (CONV_CYC)
    ) u_seq (
        .clk_i          (clk_i),
        .arst_n_i       (arst_n_i),
        .mode_i         (cfg_ff.mode),
        .conv_time_i    (cfg_ff.conv_time),
        .oneshot_go_i   (oneshot_go),
        .conv_start_o   (seq_start),
        .chan_done_o    (seq_done),
        .oneshot_done_o (seq_end),
        .chan_o         (seq_chan),
        .busy_o         (seq_busy)
    );

    // front-end control; settings are frozen per conversion at its start pulse
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            auto_run_ff     <= 1'b0;
            conv_start_o    <= 1'b0;
            conv_chan_o     <= 2'h0;
            conv_range_o    <= ltc_pkg::LTC_RANGE_AUTO;
            conv_auto_o     <= 1'b1;
            conv_time_o     <= 4'h0;
            fe_power_o      <= 1'b0;
            fe_keep_alive_o <= 1'b0;
            busy_o          <= 1'b0;
        end else begin
            auto_run_ff     <= nxt_auto;
            conv_start_o    <= seq_start;
            busy_o          <= seq_busy;
            fe_power_o      <= seq_busy;
            // standby between one-shots; the mode reads power-down after each sweep
            fe_keep_alive_o <= cfg_ff.fast_wake && !seq_busy
                               && (cfg_ff.mode != ltc_pkg::LTC_MODE_CONT);
            if (seq_start) begin
                conv_chan_o  <= seq_chan;
                conv_time_o  <= cfg_ff.conv_time;
                conv_auto_o  <= !range_fixed || auto_run_ff;
                conv_range_o <= (range_fixed && !auto_run_ff) ? cfg_ff.range : ltc_pkg::LTC_RANGE_AUTO;
            end
        end
    end

    // a fixed range reports its own code as the exponent; auto range takes the front end's
    assign sample_val.exp  = conv_auto_o ? adc_exp_i : conv_range_o;
    assign sample_val.mant = adc_mant_i;
    assign sample          = seq_done && (seq_chan == compare_channel_sel_i);

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            result_valid_o <= 1'b0;
            result_chan_o  <= 2'h0;
            result_exp_o   <= 4'h0;
            result_mant_o  <= 12'h000;
        end else begin
            result_valid_o <= seq_done;
            if (seq_done) begin
                result_chan_o <= seq_chan;
                result_exp_o  <= sample_val.exp;
                result_mant_o <= sample_val.mant;
            end
        end
    end

    ltc_cmp u_cmp (
        .clk_i             (clk_i),
        .arst_n_i          (arst_n_i),
        .sample_i          (sample),
        .value_i           (sample_val),
        .thr_lo_i          (thr_lo_ff),
        .thr_hi_i          (thr_hi_ff),
        .fault_count_i     (cfg_ff.fault_count),
        .latch_i           (cfg_ff.latch),
        .alert_pin_level_i (cfg_ff.alert_pin_level),
        .flag_clear_i      (flag_clear_i),
        .flag_hi_o         (flag_hi_o),
        .flag_lo_o         (flag_lo_o),
        .alert_o           (alert_o)
    );
endmodule

// *** verification/ltc_chk.sv ***
// port checker for the threshold configuration block
`timescale 1ns/1ns
module ltc_chk #(
    parameter int unsigned CONV_CYC [ltc_pkg::LTC_NUM_CTIME] = ltc_pkg::LTC_CONV_CYC
) (
    input wire logic        clk_i,
    input wire logic        arst_n_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic        reg_wr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic        reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic        reg_hit_o,
    input wire logic        conv_start_o,
    input wire logic [1:0]  conv_chan_o,
    input wire logic [3:0]  conv_range_o,
    input wire logic        conv_auto_o,
    input wire logic        result_valid_o,
    input wire logic [1:0]  result_chan_o,
    input wire logic [3:0]  result_exp_o,
    input wire logic        flag_hi_o,
    input wire logic        flag_lo_o,
    input wire logic        alert_o
);
    // one delay only: the bench gives every time code the same length
    localparam int DLY = CONV_CYC[0];
    logic map_hit;
    logic pol_ff;
    assign map_hit = reg_addr_i inside {8'h08, 8'h09, 8'h0A};
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pol_ff <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == 8'h0A) begin
            pol_ff <= reg_wdata_i[2];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    a_unmapped_zero: assert property (reg_rd_i && !map_hit |=> !reg_hit_o && reg_rdata_o == 16'h0000)
        else $error("unmapped read not empty");
    a_wr_rd_back: assert property (reg_wr_i && !reg_rd_i && reg_addr_i == 8'h08 ##1
        reg_rd_i && !reg_wr_i && reg_addr_i == 8'h08 |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("low threshold readback wrong");
    a_bit14_zero: assert property (reg_rd_i && reg_addr_i == 8'h0A |=> !reg_rdata_o[14])
        else $error("bit 14 read as one");
    a_conv_len: assert property (conv_start_o |-> ##DLY result_valid_o)
        else $error("conversion length wrong");
    a_chan_step: assert property (result_valid_o && result_chan_o != 2'h3 |->
        ##1 conv_start_o && conv_chan_o == result_chan_o + 2'h1)
        else $error("next channel not started");
    a_auto_code: assert property (conv_start_o |-> conv_auto_o == (conv_range_o == 4'hC))
        else $error("auto flag and range disagree");
    a_exp_range: assert property (result_valid_o && !conv_auto_o |-> result_exp_o == conv_range_o)
        else $error("exponent differs from fixed range");
    a_alert_pol: assert property ($stable(pol_ff) |-> alert_o == ((flag_hi_o | flag_lo_o) ~^ pol_ff))
        else $error("alert level wrong");
endmodule
bind ltc_top ltc_chk #(.CONV_CYC(CONV_CYC)) i_chk (.clk_i, .arst_n_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
    .reg_rd_i, .reg_rdata_o, .reg_hit_o, .conv_start_o, .conv_chan_o, .conv_range_o, .conv_auto_o,
    .result_valid_o, .result_chan_o, .result_exp_o, .flag_hi_o, .flag_lo_o, .alert_o);

// *** verification/ltc_fe_model.sv ***
// front-end model: answers each channel conversion with a level set by the bench
`timescale 1ns/1ns
module ltc_fe_model (
    input  wire logic              clk_i,
    input  wire logic              arst_n_i,
    input  wire logic [1:0]        conv_chan_i,
    input  wire logic [3:0]        conv_range_i,
    input  wire logic              conv_auto_i,
    input  wire logic              fe_power_i,
    input  wire ltc_pkg::ltc_thr_t lvl_i [4],
    output logic [3:0]             adc_exp_o,
    output logic [11:0]            adc_mant_o
);
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            adc_exp_o  <= 4'h0;
            adc_mant_o <= 12'h000;
        end else if (!fe_power_i) begin
            // powered down: churn so a stray sample never looks valid
            adc_exp_o  <= ~adc_exp_o;
            adc_mant_o <= ~adc_mant_o;
        end else begin
            adc_exp_o  <= conv_auto_i ? lvl_i[conv_chan_i].exp : conv_range_i;
            adc_mant_o <= lvl_i[conv_chan_i].mant;
        end
    end
endmodule

// *** verification/tb_top.sv ***
// self-checking bench for the threshold configuration block
`timescale 1ns/1ns
module tb_top;
    localparam int unsigned CYC [ltc_pkg::LTC_NUM_CTIME] = '{default: 8};
    logic              clk_i = 1'b0;
    logic              arst_n_i = 1'b0;
    logic [7:0]        addr = 8'h00;
    logic              wr = 1'b0;
    logic              rd = 1'b0;
    logic              clr = 1'b0;
    logic [15:0]       wdata = 16'h0000;
    logic [1:0]        sel = 2'h0;
    logic [15:0]       rdata;
    logic              hit, start, auto, pwr, valid, fhi, flo, alert, busy, kal;
    logic [1:0]        cchan, rchan;
    logic [3:0]        crange, rexp, aexp;
    logic [11:0]       amant;
    ltc_pkg::ltc_thr_t lvl [4];
    int                failures = 0;
    int                n_compared = 0;

    always #25 clk_i = ~clk_i;

    ltc_top #(.CONV_CYC(CYC)) i_dut (.clk_i, .arst_n_i, .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_hit_o(hit), .compare_channel_sel_i(sel), .flag_clear_i(clr),
        .adc_exp_i(aexp), .adc_mant_i(amant), .conv_start_o(start), .conv_chan_o(cchan), .conv_range_o(crange),
        .conv_auto_o(auto), .conv_time_o(), .fe_power_o(pwr), .fe_keep_alive_o(kal), .result_valid_o(valid),
        .result_chan_o(rchan), .result_exp_o(rexp), .result_mant_o(), .flag_hi_o(fhi), .flag_lo_o(flo),
        .alert_o(alert), .busy_o(busy));
    ltc_fe_model i_fe (.clk_i, .arst_n_i, .conv_chan_i(cchan), .conv_range_i(crange), .conv_auto_i(auto),
        .fe_power_i(pwr), .lvl_i(lvl), .adc_exp_o(aexp), .adc_mant_o(amant));

    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [15:0] cfgw(logic [3:0] rng, logic [3:0] ct, logic [1:0] md, logic lat, logic pol,
                                         logic [1:0] fc);
        return {2'b00, rng, ct, md, lat, pol, fc};
    endfunction

    // called and left at a falling edge, one idle edge first
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk_i);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk_i);
        wr = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input logic exp_hit);
        addr = a;
        rd = 1'b1;
        @(negedge clk_i);
        rd = 1'b0;
        chk(rdata, exp);
        chk({15'h0, hit}, {15'h0, exp_hit});
        @(negedge clk_i);
    endtask

    task automatic wait_res(input logic [1:0] ch);
        for (int i = 0; i < 400; i++) begin
            @(negedge clk_i);
            if (valid === 1'b1 && rchan === ch) return;
        end
        failures++;
        wrap_up();
    endtask

    // counts result pulses until the sweep has gone idle
    task automatic wait_idle(output int n);
        n = 0;
        for (int i = 0; i < 400; i++) begin
            @(negedge clk_i);
            n += int'(valid === 1'b1);
            if (i > 2 && busy === 1'b0) return;
        end
        failures++;
        wrap_up();
    endtask

    task automatic t_reset();
        rd_chk(8'h08, 16'h0000, 1'b1);
        rd_chk(8'h09, 16'hBFFF, 1'b1);
        rd_chk(8'h0A, cfgw(4'hC, 4'h8, 2'h0, 1'b1, 1'b0, 2'h0), 1'b1);
        rd_chk(8'h0B, 16'h0000, 1'b0);
        $display("test reset done");
    endtask

    task automatic t_regs();
        wr_reg(8'h08, 16'hA5A5);
        rd_chk(8'h08, 16'hA5A5, 1'b1);
        wr_reg(8'h09, 16'h5A5A);
        rd_chk(8'h09, 16'h5A5A, 1'b1);
        for (int ct = 0; ct < 12; ct++) begin
            wr_reg(8'h0A, 16'hC000 | cfgw(4'h6, ct[3:0], 2'h0, ct[0], ct[1], ct[1:0]));
            rd_chk(8'h0A, 16'h8000 | cfgw(4'h6, ct[3:0], 2'h0, ct[0], ct[1], ct[1:0]), 1'b1);
        end
        chk({15'h0, kal}, 16'h0001);
        $display("test registers done");
    endtask

    task automatic t_oneshot(input logic [1:0] md, input logic [3:0] rng);
        int n;
        wr_reg(8'h0A, cfgw(rng, 4'h0, md, 1'b1, 1'b0, 2'h0));
        wait_idle(n);
        chk(n[15:0], 16'h0004);
        chk({12'h0, rexp}, {12'h0, (md == 2'h1) ? lvl[3].exp : rng});
        rd_chk(8'h0A, cfgw(rng, 4'h0, 2'h0, 1'b1, 1'b0, 2'h0), 1'b1);
        $display("test one-shot mode %0d range %0d done", md, rng);
    endtask

    task automatic t_fault();
        int n;
        wr_reg(8'h08, 16'h2100);
        for (int fc = 0; fc < 4; fc++) begin
            lvl[0] = '{exp: 4'h2, mant: 12'h200};
            wr_reg(8'h0A, cfgw(4'hC, 4'h0, 2'h3, 1'b0, 1'b1, fc[1:0]));
            wait_res(2'h0);
            chk({13'h0, fhi, flo, alert}, 16'h0000);
            lvl[0] = '{exp: 4'h0, mant: 12'h010};
            for (int k = 1; k <= (1 << fc); k++) begin
                wait_res(2'h0);
                chk({13'h0, fhi, flo, alert}, (k == (1 << fc)) ? 16'h0003 : 16'h0000);
            end
        end
        lvl[0] = '{exp: 4'h2, mant: 12'h200};
        wait_res(2'h0);
        wr_reg(8'h0A, 16'h0000);
        wait_idle(n);
        $display("test fault count done");
    endtask

    task automatic t_latch();
        int n;
        wr_reg(8'h09, 16'h0800);
        sel = 2'h2;
        lvl[0] = '{exp: 4'h0, mant: 12'h010};
        lvl[2] = '{exp: 4'h1, mant: 12'h800};
        wr_reg(8'h0A, cfgw(4'hC, 4'h0, 2'h3, 1'b1, 1'b0, 2'h0));
        wait_res(2'h2);
        chk({13'h0, fhi, flo, alert}, 16'h0004);
        lvl[2] = '{exp: 4'h0, mant: 12'h600};
        wait_res(2'h2);
        chk({13'h0, fhi, flo, alert}, 16'h0004);
        clr = 1'b1;
        @(negedge clk_i);
        clr = 1'b0;
        chk({13'h0, fhi, flo, alert}, 16'h0001);
        wr_reg(8'h0A, 16'h0000);
        wait_idle(n);
        $display("test latched flags done");
    endtask

    initial begin
        foreach (lvl[i]) lvl[i] = '{exp: 4'h3, mant: 12'h400};
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        arst_n_i = 1'b1;
        t_reset();
        t_regs();
        for (int r = 0; r < 7; r++) t_oneshot(2'h2, r[3:0]);
        t_oneshot(2'h1, 4'h5);
        t_fault();
        t_latch();
        wrap_up();
    end
endmodule
